/* File: core/tcu_pkg.sv */
/*
 * shared constants and carrier types of the timer capture unit:
 * register offsets, field positions, reset values, mode codes.
 * assumes a 32-bit apb register bus with byte addresses on paddr.
 */
package tcu_pkg;

   // ****************************************
   // register map (byte addresses)
   // ****************************************
   localparam logic [7:0] OFF_CONTROL  = 8'h00;
   localparam logic [7:0] OFF_VAL_LOW  = 8'h04;
   localparam logic [7:0] OFF_VAL_HIGH = 8'h08;
   localparam logic [7:0] OFF_TB_CTRL  = 8'h0C;
   localparam logic [7:0] OFF_TB_LOW   = 8'h10;
   localparam logic [7:0] OFF_TB_HIGH  = 8'h14;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;

   // ****************************************
   // fields and reset values
   // ****************************************
   localparam int MODE_LSB    = 0;
   localparam int MODE_MSB    = 3;
   localparam int TB_EN_BIT   = 0;
   localparam int TB_EXT_BIT  = 1;
   localparam int IRQ_CAP_BIT = 0;

   localparam logic [7:0]  CONTROL_RST = 8'h00;
   localparam logic [15:0] VALUE_RST   = 16'h0000;
   localparam logic [1:0]  TB_CTRL_RST = 2'h0;
   localparam logic        STAT_RST    = 1'b0;
   localparam logic        MASK_RST    = 1'b0;

   // ****************************************
   // mode codes of ccp_mode_select
   // ****************************************
   localparam logic [3:0] MODE_OFF        = 4'h0;
   localparam logic [3:0] MODE_CAP_FALL   = 4'h4;
   localparam logic [3:0] MODE_CAP_RISE   = 4'h5;
   localparam logic [3:0] MODE_CAP_RISE4  = 4'h6;
   localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;

   // ****************************************
   // timing counts
   // ****************************************
   localparam int         INST_DIV      = 4;
   localparam logic [4:0] PRE_EVERY     = 5'h01;
   localparam logic [4:0] PRE_FOURTH    = 5'h04;
   localparam logic [4:0] PRE_SIXTEENTH = 5'h10;

   typedef enum logic [1:0] {EV_FALL, EV_RISE, EV_RISE4, EV_RISE16} tcu_event_t;

   typedef struct packed {
      logic       active;
      tcu_event_t ev;
   } tcu_cap_cfg_t;

   typedef struct packed {
      logic enable;
      logic ext_sel;
      logic sleep;
   } tcu_tb_cfg_t;

   function automatic logic [4:0] tcu_ev_limit(input tcu_event_t ev);
      case (ev)
         EV_RISE4:  return PRE_FOURTH;
         EV_RISE16: return PRE_SIXTEENTH;
         default:   return PRE_EVERY;
      endcase
   endfunction : tcu_ev_limit

endpackage : tcu_pkg

/* File: core/tcu_edge_prescaler.sv */
/*
 * synchroniser, edge detector and event prescaler of the capture input.
 * assumes pin is an asynchronous level and cfg comes from flip-flops.
 */
`timescale 1ns/1ns
module tcu_edge_prescaler #(
   parameter int PRESC_W = 4
) (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic                  pin,
   input  wire tcu_pkg::tcu_cap_cfg_t cfg,
   output logic                       cap_pulse
);

   if (PRESC_W < 4) begin : g_chk
      $error("PRESC_W must hold a count of sixteen");
   end

   logic               sync_a;
   logic               sync_b;
   logic               prev;
   logic [PRESC_W-1:0] cnt;
   logic [PRESC_W-1:0] next_cnt;
   logic               rise;
   logic               fall;
   logic               hit;

   always_comb begin
      rise      = sync_b & ~prev;
      fall      = ~sync_b & prev;
      // compared at five bits so that a limit of sixteen is not cut to zero
      hit       = ({1'b0, cnt[3:0]} + 5'h01) == tcu_pkg::tcu_ev_limit(cfg.ev);
      next_cnt  = cnt;
      cap_pulse = 1'b0;
      if (!cfg.active) begin
         next_cnt = '0;
      end else if (cfg.ev == tcu_pkg::EV_FALL) begin
         cap_pulse = fall;
      end else if (rise) begin
         // counter survives a switch between rising modes
         if (hit) begin
            cap_pulse = 1'b1;
            next_cnt  = '0;
         end else begin
            next_cnt = cnt + PRESC_W'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_a <= 1'b0;
         sync_b <= 1'b0;
         prev   <= 1'b0;
         cnt    <= '0;
      end else begin
         sync_a <= pin;
         sync_b <= sync_a;
         prev   <= sync_b;
         cnt    <= next_cnt;
      end
   end

   edge_qual_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_pulse |-> (cfg.ev == tcu_pkg::EV_FALL ? fall : rise))
      else $error("capture pulse without the selected edge");

   sync_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_pulse && cfg.ev != tcu_pkg::EV_FALL |-> $past(pin, 2) && !$past(pin, 3))
      else $error("rising capture not three cycles after pin rise");

   presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
      !cfg.active |=> cnt == '0)
      else $error("prescaler not cleared while inactive");

   presc_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.active && cfg.ev != tcu_pkg::EV_FALL && !rise |=> $stable(cnt))
      else $error("prescaler moved without a rising edge");

endmodule : tcu_edge_prescaler

/* File: core/tcu_timebase.sv */
/*
 * 16-bit capture timebase, ticked by the instruction clock (pclk/4)
 * or by rising edges of an external clock pin.
 * assumes ext_in is a slow asynchronous level.
 */
`timescale 1ns/1ns
module tcu_timebase #(
   parameter int TB_W = 16
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 ext_in,
   input  wire tcu_pkg::tcu_tb_cfg_t cfg,
   output logic [TB_W-1:0]           count
);

   if (TB_W != 16) begin : g_chk
      $error("TB_W must be 16, the capture pair is two bytes");
   end

   logic            ext_a;
   logic            ext_b;
   logic            ext_prev;
   logic [1:0]      div;
   logic [1:0]      next_div;
   logic [TB_W-1:0] next_count;
   logic            ext_rise;
   logic            tick;

   always_comb begin
      ext_rise   = ext_b & ~ext_prev;
      next_div   = div;
      tick       = 1'b0;
      next_count = count;
      // instruction clock stops in sleep, count is kept
      if (!cfg.ext_sel && !cfg.sleep) begin
         next_div = div + 2'h1;
         tick     = (div == 2'(tcu_pkg::INST_DIV - 1));
      end
      if (cfg.ext_sel) begin
         tick = ext_rise;
      end
      if (cfg.enable && tick) begin
         next_count = count + TB_W'(1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_a    <= 1'b0;
         ext_b    <= 1'b0;
         ext_prev <= 1'b0;
         div      <= 2'h0;
         count    <= '0;
      end else begin
         ext_a    <= ext_in;
         ext_b    <= ext_a;
         ext_prev <= ext_b;
         div      <= next_div;
         count    <= next_count;
      end
   end

   sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.sleep && !cfg.ext_sel |=> $stable(count))
      else $error("timebase moved in sleep on instruction clock");

   ext_count_a: assert property (@(posedge pclk) disable iff (!presetn)
      cfg.enable && cfg.ext_sel && ext_rise |=> count == $past(count) + TB_W'(1))
      else $error("external tick lost");

endmodule : tcu_timebase

/* File: core/tcu_capture_top.sv */
/*
 * timer capture unit: apb register slave, capture of the timebase
 * into the value pair, sticky capture flag with mask and irq line.
 * assumes an apb3 master on pclk; pin, ext clock and sleep are levels.
 */
`timescale 1ns/1ns
module tcu_capture_top #(
   parameter int TB_W    = 16,
   parameter int PRESC_W = 4
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [7:0]  paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        capture_input_pin,
   input  wire logic        ext_clk_in,
   input  wire logic        sleep,
   output logic             irq
);

   // ****************************************
   // state
   // ****************************************
   logic [7:0]  ccp_control;
   logic [7:0]  next_ccp_control;
   logic [15:0] capture_value;
   logic [15:0] next_capture_value;
   logic [1:0]  tb_control;
   logic [1:0]  next_tb_control;
   logic        capture_irq_flag;
   logic        next_capture_irq_flag;
   logic        capture_irq_enable;
   logic        next_capture_irq_enable;
   logic        next_irq;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;

   logic [TB_W-1:0]       tb_count;
   logic                  cap_pulse;
   logic                  setup;
   logic                  wr;
   logic [31:0]           rd_word;
   tcu_pkg::tcu_cap_cfg_t cap_cfg;
   tcu_pkg::tcu_tb_cfg_t  tb_cfg;

   // ****************************************
   // address decode
   // ****************************************
   function automatic logic tcu_mapped(input logic [7:0] a);
      case (a)
         tcu_pkg::OFF_CONTROL,
         tcu_pkg::OFF_VAL_LOW,
         tcu_pkg::OFF_VAL_HIGH,
         tcu_pkg::OFF_TB_CTRL,
         tcu_pkg::OFF_TB_LOW,
         tcu_pkg::OFF_TB_HIGH,
         tcu_pkg::OFF_IRQ_STAT,
         tcu_pkg::OFF_IRQ_MASK: return 1'b1;
         default:               return 1'b0;
      endcase
   endfunction : tcu_mapped

   function automatic tcu_pkg::tcu_cap_cfg_t tcu_decode(input logic [3:0] m);
      tcu_pkg::tcu_cap_cfg_t c;
      c.active = 1'b1;
      case (m)
         tcu_pkg::MODE_CAP_FALL:   c.ev = tcu_pkg::EV_FALL;
         tcu_pkg::MODE_CAP_RISE:   c.ev = tcu_pkg::EV_RISE;
         tcu_pkg::MODE_CAP_RISE4:  c.ev = tcu_pkg::EV_RISE4;
         tcu_pkg::MODE_CAP_RISE16: c.ev = tcu_pkg::EV_RISE16;
         default: begin
            // off and every non-capture code
            c.active = 1'b0;
            c.ev     = tcu_pkg::EV_FALL;
         end
      endcase
      return c;
   endfunction : tcu_decode

   // ****************************************
   // capture path
   // ****************************************
   always_comb begin
      cap_cfg        = tcu_decode(ccp_control[tcu_pkg::MODE_MSB:tcu_pkg::MODE_LSB]);
      tb_cfg.enable  = tb_control[tcu_pkg::TB_EN_BIT];
      tb_cfg.ext_sel = tb_control[tcu_pkg::TB_EXT_BIT];
      tb_cfg.sleep   = sleep;
   end

   // a switch between capture codes goes straight into the prescaler,
   // so edge history and count carry over and may fire early
   tcu_edge_prescaler #(
      .PRESC_W (PRESC_W)
   ) u_edge (
      .pclk      (pclk),
      .presetn   (presetn),
      .pin       (capture_input_pin),
      .cfg       (cap_cfg),
      .cap_pulse (cap_pulse)
   );

   // capture keeps running in sleep; only the tick source decides
   tcu_timebase #(
      .TB_W (TB_W)
   ) u_timebase (
      .pclk    (pclk),
      .presetn (presetn),
      .ext_in  (ext_clk_in),
      .cfg     (tb_cfg),
      .count   (tb_count)
   );

   // ****************************************
   // apb slave and registers
   // ****************************************
   always_comb begin
      setup = psel & ~penable;
      wr    = psel & penable & pready & pwrite & ~pslverr;

      case (paddr)
         tcu_pkg::OFF_CONTROL:  rd_word = {24'h000000, ccp_control};
         tcu_pkg::OFF_VAL_LOW:  rd_word = {24'h000000, capture_value[7:0]};
         tcu_pkg::OFF_VAL_HIGH: rd_word = {24'h000000, capture_value[15:8]};
         tcu_pkg::OFF_TB_CTRL:  rd_word = {30'h00000000, tb_control};
         tcu_pkg::OFF_TB_LOW:   rd_word = {24'h000000, tb_count[7:0]};
         tcu_pkg::OFF_TB_HIGH:  rd_word = {24'h000000, tb_count[15:8]};
         tcu_pkg::OFF_IRQ_STAT: rd_word = {31'h00000000, capture_irq_flag};
         tcu_pkg::OFF_IRQ_MASK: rd_word = {31'h00000000, capture_irq_enable};
         default:               rd_word = 32'h00000000;
      endcase

      // one wait-free access: answer registered during setup
      next_pready  = setup;
      next_pslverr = setup & ~tcu_mapped(paddr);
      next_prdata  = (setup && !pwrite) ? rd_word : 32'h00000000;

      next_ccp_control        = ccp_control;
      next_capture_value      = capture_value;
      next_tb_control         = tb_control;
      next_capture_irq_flag   = capture_irq_flag;
      next_capture_irq_enable = capture_irq_enable;

      if (wr) begin
         case (paddr)
            tcu_pkg::OFF_CONTROL:  next_ccp_control = pwdata[7:0];
            tcu_pkg::OFF_VAL_LOW:  next_capture_value[7:0] = pwdata[7:0];
            tcu_pkg::OFF_VAL_HIGH: next_capture_value[15:8] = pwdata[7:0];
            tcu_pkg::OFF_TB_CTRL:  next_tb_control = pwdata[1:0];
            tcu_pkg::OFF_IRQ_STAT: begin
               if (pwdata[tcu_pkg::IRQ_CAP_BIT]) begin
                  next_capture_irq_flag = 1'b0;
               end
            end
            tcu_pkg::OFF_IRQ_MASK: begin
               next_capture_irq_enable = pwdata[tcu_pkg::IRQ_CAP_BIT];
            end
            default: begin
            end
         endcase
      end

      // hardware capture beats a software write in the same cycle
      if (cap_pulse) begin
         next_capture_value    = tb_count;
         next_capture_irq_flag = 1'b1;
      end

      next_irq = next_capture_irq_flag & next_capture_irq_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ccp_control        <= tcu_pkg::CONTROL_RST;
         capture_value      <= tcu_pkg::VALUE_RST;
         tb_control         <= tcu_pkg::TB_CTRL_RST;
         capture_irq_flag   <= tcu_pkg::STAT_RST;
         capture_irq_enable <= tcu_pkg::MASK_RST;
         irq                <= 1'b0;
         prdata             <= 32'h00000000;
         pready             <= 1'b0;
         pslverr            <= 1'b0;
      end else begin
         ccp_control        <= next_ccp_control;
         capture_value      <= next_capture_value;
         tb_control         <= next_tb_control;
         capture_irq_flag   <= next_capture_irq_flag;
         capture_irq_enable <= next_capture_irq_enable;
         irq                <= next_irq;
         prdata             <= next_prdata;
         pready             <= next_pready;
         pslverr            <= next_pslverr;
      end
   end

   // ****************************************
   // checks
   // ****************************************
   capture_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_pulse |=> capture_value == $past(tb_count))
      else $error("captured value differs from timebase");

   overwrite_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_pulse && capture_irq_flag |=> capture_value == $past(tb_count))
      else $error("capture over an unserviced value did not overwrite");

   flag_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      cap_pulse |=> capture_irq_flag)
      else $error("capture did not set the flag");

   flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
      capture_irq_flag && !(wr && paddr == tcu_pkg::OFF_IRQ_STAT && pwdata[0])
      |=> capture_irq_flag)
      else $error("flag dropped without a clear");

   irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
      irq == (capture_irq_flag & capture_irq_enable))
      else $error("irq differs from masked flag");

   apb_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
      psel && !penable |=> pready ##1 !pready)
      else $error("access phase not answered in one cycle");

   mode_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      ccp_control[3:0] == tcu_pkg::MODE_OFF |-> !cap_pulse)
      else $error("capture while the unit is off");

endmodule : tcu_capture_top

/* File: verif/tcu_event_source.sv */
/*
 * far-side model: drives the capture input pin and the external timebase clock.
 * assumes pclk is the bench clock; the bench calls the tasks by hierarchy.
 */
`timescale 1ns/1ns
module tcu_event_source (
   input  wire logic pclk,
   output logic      pin,
   output logic      ext_clk
);
   initial begin
      pin     = 1'b0;
      ext_clk = 1'b0;
   end

   // each level is held 3 cycles so that every edge survives the synchroniser
   task automatic set_pin(input logic lvl);
      @(posedge pclk);
      pin <= lvl;
      repeat (3) @(posedge pclk);
   endtask : set_pin

   task automatic pin_rises(input int n);
      repeat (n) begin
         set_pin(1'b1);
         set_pin(1'b0);
      end
   endtask : pin_rises

   // slow clock sampled by pclk, never the full system clock
   task automatic ext_ticks(input int n);
      repeat (n) begin
         @(posedge pclk);
         ext_clk <= 1'b1;
         repeat (3) @(posedge pclk);
         ext_clk <= 1'b0;
         repeat (3) @(posedge pclk);
      end
   endtask : ext_ticks
endmodule : tcu_event_source

/* File: verif/timer_capture_unit_bench.sv */
/*
 * self-checking bench of the timer capture unit over apb.
 * assumes tcu_capture_top and tcu_event_source; one 100 MHz clock.
 */
`timescale 1ns/1ns
module timer_capture_unit_bench;
   localparam logic [7:0] STAT = tcu_pkg::OFF_IRQ_STAT;
   localparam logic [7:0] CTRL = tcu_pkg::OFF_CONTROL;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        pready;
   logic        pslverr;
   logic        irq;
   logic        sleep;
   logic        capture_input_pin;
   logic        ext_clk_in;
   logic        perr;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rdata;
   int          bad_count;
   int          comparisons;

   tcu_capture_top i_tcu_capture_top (
      .pclk              (pclk),
      .presetn           (presetn),
      .paddr             (paddr),
      .psel              (psel),
      .penable           (penable),
      .pwrite            (pwrite),
      .pwdata            (pwdata),
      .prdata            (prdata),
      .pready            (pready),
      .pslverr           (pslverr),
      .capture_input_pin (capture_input_pin),
      .ext_clk_in        (ext_clk_in),
      .sleep             (sleep),
      .irq               (irq)
   );

   tcu_event_source i_tcu_event_source (
      .pclk    (pclk),
      .pin     (capture_input_pin),
      .ext_clk (ext_clk_in)
   );

   always #5 pclk = ~pclk;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // ****************************************
   // apb master
   // ****************************************
   task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      // pready, prdata and pslverr are taken at the edge that completes the access
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      chk({31'h0, pready}, 32'h1);
      rdata   = prdata;
      perr    = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      apb(1'b0, a, 8'h00);
      chk(rdata, {24'h0, exp});
   endtask : rd

   // ****************************************
   // scenarios
   // ****************************************
   task automatic test_reset;
      for (int a = 0; a < 32; a += 4) begin
         rd(8'(a), 8'h00);
      end
      wr(tcu_pkg::OFF_TB_LOW, 8'h5A);
      rd(tcu_pkg::OFF_TB_LOW, 8'h00);
      rd(8'h20, 8'h00);
      chk({31'h0, perr}, 32'h1);
      $display("done: reset values and unmapped access");
   endtask : test_reset

   task automatic test_capture;
      wr(tcu_pkg::OFF_TB_CTRL, 8'h03);
      i_tcu_event_source.ext_ticks(5);
      wr(CTRL, {4'h0, tcu_pkg::MODE_CAP_RISE});
      wr(STAT, 8'h01);
      wr(tcu_pkg::OFF_IRQ_MASK, 8'h01);
      i_tcu_event_source.pin_rises(1);
      rd(tcu_pkg::OFF_VAL_LOW, 8'h05);
      rd(tcu_pkg::OFF_VAL_HIGH, 8'h00);
      chk({31'h0, irq}, 32'h1);
      wr(STAT, 8'h00);
      rd(STAT, 8'h01);
      wr(STAT, 8'h01);
      rd(STAT, 8'h00);
      chk({31'h0, irq}, 32'h0);
      i_tcu_event_source.ext_ticks(3);
      i_tcu_event_source.pin_rises(1);
      rd(tcu_pkg::OFF_VAL_LOW, 8'h08);
      $display("done: capture, flag and overwrite");
   endtask : test_capture

   task automatic test_sleep;
      wr(tcu_pkg::OFF_IRQ_MASK, 8'h00);
      wr(STAT, 8'h01);
      @(posedge pclk);
      sleep <= 1'b1;
      i_tcu_event_source.ext_ticks(2);
      i_tcu_event_source.pin_rises(1);
      rd(tcu_pkg::OFF_VAL_LOW, 8'h0A);
      rd(STAT, 8'h01);
      // a second capture while the flag still stands replaces the value
      i_tcu_event_source.ext_ticks(1);
      i_tcu_event_source.pin_rises(1);
      rd(tcu_pkg::OFF_VAL_LOW, 8'h0B);
      chk({31'h0, irq}, 32'h0);
      wr(tcu_pkg::OFF_TB_CTRL, 8'h01);
      repeat (40) @(posedge pclk);
      rd(tcu_pkg::OFF_TB_LOW, 8'h0B);
      sleep <= 1'b0;
      repeat (40) @(posedge pclk);
      apb(1'b0, tcu_pkg::OFF_TB_LOW, 8'h00);
      chk({31'h0, rdata > 32'h0000000A}, 32'h1);
      wr(tcu_pkg::OFF_TB_CTRL, 8'h00);
      $display("done: sleep behaviour");
   endtask : test_sleep

   task automatic test_modes;
      logic [3:0] modes [4];
      int         cnt [4];
      modes = '{tcu_pkg::MODE_CAP_FALL, tcu_pkg::MODE_CAP_RISE,
                tcu_pkg::MODE_CAP_RISE4, tcu_pkg::MODE_CAP_RISE16};
      cnt   = '{1, 1, 4, 16};
      for (int m = 0; m < 4; m++) begin
         wr(CTRL, 8'h00);
         wr(CTRL, {4'h0, modes[m]});
         wr(STAT, 8'h01);
         i_tcu_event_source.pin_rises(cnt[m] - 1);
         rd(STAT, 8'h00);
         i_tcu_event_source.set_pin(1'b1);
         rd(STAT, (m == 0) ? 8'h00 : 8'h01);
         i_tcu_event_source.set_pin(1'b0);
         rd(STAT, 8'h01);
      end
      $display("done: event modes");
   endtask : test_modes

   task automatic test_presc(input logic use_reset);
      wr(CTRL, 8'h00);
      wr(CTRL, {4'h0, tcu_pkg::MODE_CAP_RISE4});
      i_tcu_event_source.pin_rises(2);
      if (use_reset) begin
         @(posedge pclk);
         presetn <= 1'b0;
         repeat (2) @(posedge pclk);
         presetn <= 1'b1;
      end else begin
         wr(CTRL, 8'h01);
         wr(STAT, 8'h01);
         i_tcu_event_source.pin_rises(1);
         rd(STAT, 8'h00);
      end
      wr(CTRL, {4'h0, tcu_pkg::MODE_CAP_RISE4});
      wr(STAT, 8'h01);
      i_tcu_event_source.pin_rises(3);
      rd(STAT, 8'h00);
      i_tcu_event_source.pin_rises(1);
      rd(STAT, 8'h01);
      if (!use_reset) begin
         // direct switch keeps the count: sixteenth edge comes early
         i_tcu_event_source.pin_rises(2);
         wr(CTRL, {4'h0, tcu_pkg::MODE_CAP_RISE16});
         wr(STAT, 8'h01);
         i_tcu_event_source.pin_rises(13);
         rd(STAT, 8'h00);
         i_tcu_event_source.pin_rises(1);
         rd(STAT, 8'h01);
      end
      $display("done: prescaler clear, reset %0b", use_reset);
   endtask : test_presc

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : report_and_stop

   initial begin
      pclk        = 1'b0;
      presetn     = 1'b0;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h0;
      sleep       = 1'b0;
      bad_count   = 0;
      comparisons = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      test_reset;
      test_capture;
      test_sleep;
      test_modes;
      test_presc(1'b0);
      test_presc(1'b1);
      report_and_stop;
   end

   // whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge pclk);
      bad_count++;
      report_and_stop;
   end
endmodule : timer_capture_unit_bench
